// >>> hw/awg_pkg.sv
// Constants, field layout and encodings of the trigger and clock control.
// Assumes a 40 MHz APB clock and 32-bit register words.
package awg_pkg;
  // ==========================================
  // Clock
  localparam int CLK_HZ          = 40_000_000;
  localparam int RATE_MIN_INT_HZ = 1_000;
  localparam int RATE_MIN_EXT_HZ = 50_000;
  localparam int CLK_DIV_MAX_INT = CLK_HZ / RATE_MIN_INT_HZ;
  localparam int CLK_DIV_MAX_EXT = CLK_HZ / RATE_MIN_EXT_HZ;
  // ==========================================
  // Register offsets
  localparam logic [7:0] CTRL_OFS        = 8'h00;
  localparam logic [7:0] TRIG_DELAY_OFS  = 8'h04;
  localparam logic [7:0] PULSE_WIDTH_OFS = 8'h08;
  localparam logic [7:0] MEM_DEPTH_OFS   = 8'h0c;
  localparam logic [7:0] CLK_DIV_OFS     = 8'h10;
  localparam logic [7:0] SYNC_DIV_OFS    = 8'h14;
  localparam logic [7:0] SLOW_DIV_OFS    = 8'h18;
  localparam logic [7:0] STATUS_OFS      = 8'h1c;
  // ==========================================
  // Control fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_EDGE_LSB = 3;
  localparam int CTRL_EN_BIT   = 5;
  localparam int CTRL_SRC_LSB  = 6;
  localparam int CTRL_CHAN_LSB = 9;
  localparam int CTRL_GATE_BIT = 11;
  localparam int CTRL_SLOW_BIT = 12;
  localparam int CTRL_W        = 13;
  // ==========================================
  // Reset values and limits
  localparam logic [31:0] CTRL_RST     = 32'h0;
  localparam logic [31:0] DEPTH_RST    = 32'h8;
  localparam logic [31:0] CLK_DIV_RST  = 32'h1;
  localparam logic [31:0] SYNC_DIV_RST = 32'h2;
  localparam logic [31:0] SLOW_DIV_RST = 32'h8;
  localparam int TRIG_CNT_W   = 16;
  localparam int DEPTH_MIN    = 8;
  localparam int SYNC_DIV_MIN = 2;
  localparam int SYNC_DIV_MAX = 8190;
  localparam int SLOW_DIV_MIN = 8;
  localparam int SLOW_DIV_MAX = 524280;
  // ==========================================
  // Encodings
  typedef enum logic [2:0] {
    M_SINGLE = 3'b000, M_FIFO = 3'b001, M_REPEAT = 3'b010,
    M_RESTART = 3'b011, M_SEQUENCE = 3'b100
  } run_mode_t;
  typedef enum logic [1:0] {E_RISE = 2'b00, E_FALL = 2'b01, E_BOTH = 2'b10} trig_edge_t;
  typedef enum logic [2:0] {
    C_PLL = 3'b000, C_QUARTZ = 3'b001, C_EXT = 3'b010,
    C_EXT_DIV = 3'b011, C_EXT_REF = 3'b100, C_SYNC = 3'b101
  } clk_src_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_ARMED = 3'b001, S_QUALIFY = 3'b010,
    S_DELAY = 3'b011, S_RUN = 3'b100, S_DONE = 3'b101
  } state_t;
endpackage : awg_pkg

// >>> hw/two_entry_buffer.sv
// Two-entry buffer with valid/ready on both sides.
// Assumes one clock; the drain side may stall at any time.
module two_entry_buffer #(
  parameter int WIDTH = 32
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem [2];
  logic             wp;
  logic             rp;
  logic [1:0]       cnt;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt != 2'h2);
  assign out_valid = (cnt != 2'h0);
  assign out_data  = mem[rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // ==========================================
  // Storage
  always_ff @(posedge pclk)
  begin
    if (push)
    begin
      mem[wp] <= in_data;
    end
  end

  // ==========================================
  // Pointers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wp  <= 1'b0;
      rp  <= 1'b0;
      cnt <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        wp <= ~wp;
      end
      if (pop)
      begin
        rp <= ~rp;
      end
      cnt <= 2'(cnt + {1'b0, push} - {1'b0, pop});
    end
  end
endmodule : two_entry_buffer

// >>> hw/awg_trig_clk.sv
// Trigger and sample-clock control with APB registers.
// Assumes pins are asynchronous to pclk and a replay datapath
// that takes sample indexes through a ready/valid port.

// What this block does
// - Five selectable run modes: single, FIFO, repeat, restart, sequence.
// - Trigger fires on rising, falling or both edges as programmed.
// - Pulse qualifier and delay count 0 to 65535 samples.
// - Depth from 8 to memory per channel, multiple of 4.
// - Each internal trigger event gives one rising edge on trigger out.
// - Gated replay ends on 2-sample boundary with one channel, else 1.
// - Sample clock source chosen among six sources by software.
// - Internal rate at least 1 kS/s, or 50 kS/s with external reference.
// - Internal rate set by integer divider, fine step per decade.
// - External clock advances timing on its rising edge only.
// - Sync divider takes even values 2 to 8190.
// - Slow clock divider takes multiples of 8 up to 524280.
module awg_trig_clk #(
  parameter int MEM_SAMPLES = 1048576
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        trig_in,
  input  wire logic        ext_clk_in,
  input  wire logic        sync_clk_in,
  output logic             trig_out,
  output logic             sync_clk_out,
  output logic             slow_tick,
  output logic             smp_valid,
  input  wire logic        smp_ready,
  output logic      [31:0] smp_index
);
  logic [awg_pkg::CTRL_W-1:0]     ctrl;
  logic [awg_pkg::TRIG_CNT_W-1:0] trig_delay;
  logic [awg_pkg::TRIG_CNT_W-1:0] pulse_width;
  logic [31:0]                    depth;
  logic [31:0]                    clk_div;
  logic [12:0]                    sync_div;
  logic [18:0]                    slow_div;
  awg_pkg::state_t                state;
  awg_pkg::state_t                next_state;
  logic [2:0]                     pin_meta;
  logic [2:0]                     pin_sync;
  logic [2:0]                     pin_d;
  logic                           ext_rise;
  logic                           syn_rise;
  logic                           trig_s;
  logic                           trig_hit;
  logic                           trig_lvl;
  logic                           base_ev;
  logic                           div_active;
  logic [31:0]                    div_cnt;
  logic                           smp_tick;
  logic [awg_pkg::TRIG_CNT_W-1:0] tcnt;
  logic [31:0]                    idx;
  logic                           closing;
  logic                           buf_ready;
  logic                           step;
  logic                           last;
  logic [11:0]                    sync_cnt;
  logic [18:0]                    slow_cnt;
  logic                           wr;
  logic                           bad_wr;
  logic                           mapped;

  function automatic logic [1:0] chan_shift(input logic [1:0] code);
    chan_shift = code;
  endfunction : chan_shift

  awg_pkg::run_mode_t  mode;
  awg_pkg::trig_edge_t edge_sel;
  awg_pkg::clk_src_t   src;
  assign mode     = awg_pkg::run_mode_t'(ctrl[awg_pkg::CTRL_MODE_LSB +: 3]);
  assign edge_sel = awg_pkg::trig_edge_t'(ctrl[awg_pkg::CTRL_EDGE_LSB +: 2]);
  assign src      = awg_pkg::clk_src_t'(ctrl[awg_pkg::CTRL_SRC_LSB +: 3]);

  // ==========================================
  // APB slave, zero wait states
  assign pready = 1'b1;
  assign wr     = psel && penable && pwrite;
  always_comb
  begin
    mapped = (paddr[1:0] == 2'b00) && (paddr <= awg_pkg::STATUS_OFS);
    bad_wr = 1'b0;
    if (pwrite)
    begin
      unique case (paddr)
        // Mode, edge and source codes checked
        awg_pkg::CTRL_OFS:
          bad_wr = (pwdata[awg_pkg::CTRL_MODE_LSB +: 3] > 3'b100)
                || (pwdata[awg_pkg::CTRL_EDGE_LSB +: 2] == 2'b11)
                || (pwdata[awg_pkg::CTRL_SRC_LSB +: 3] > 3'b101)
                || (pwdata[awg_pkg::CTRL_CHAN_LSB +: 2] == 2'b11);
        awg_pkg::TRIG_DELAY_OFS, awg_pkg::PULSE_WIDTH_OFS:
          bad_wr = (pwdata[31:16] != 16'h0);
        awg_pkg::MEM_DEPTH_OFS:
          bad_wr = (pwdata < awg_pkg::DEPTH_MIN) || (pwdata[1:0] != 2'b00)
                || (pwdata > (MEM_SAMPLES >> chan_shift(ctrl[awg_pkg::CTRL_CHAN_LSB +: 2])));
        awg_pkg::CLK_DIV_OFS:
          bad_wr = (pwdata == 32'h0) || (pwdata > ((src == awg_pkg::C_EXT_REF)
                ? awg_pkg::CLK_DIV_MAX_EXT : awg_pkg::CLK_DIV_MAX_INT));
        awg_pkg::SYNC_DIV_OFS:
          bad_wr = pwdata[0] || (pwdata < awg_pkg::SYNC_DIV_MIN)
                || (pwdata > awg_pkg::SYNC_DIV_MAX);
        // Slow divider in steps of 8
        awg_pkg::SLOW_DIV_OFS:
          bad_wr = (pwdata[2:0] != 3'b000) || (pwdata < awg_pkg::SLOW_DIV_MIN)
                || (pwdata > awg_pkg::SLOW_DIV_MAX);
        default:
          bad_wr = 1'b1;
      endcase
    end
  end
  assign pslverr = psel && penable && (!mapped || bad_wr);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl        <= awg_pkg::CTRL_W'(awg_pkg::CTRL_RST);
      trig_delay  <= '0;
      pulse_width <= '0;
      depth       <= awg_pkg::DEPTH_RST;
      clk_div     <= awg_pkg::CLK_DIV_RST;
      sync_div    <= 13'(awg_pkg::SYNC_DIV_RST);
      slow_div    <= 19'(awg_pkg::SLOW_DIV_RST);
    end
    else if (wr && mapped && !bad_wr)
    begin
      unique case (paddr)
        awg_pkg::CTRL_OFS:        ctrl        <= pwdata[awg_pkg::CTRL_W-1:0];
        awg_pkg::TRIG_DELAY_OFS:  trig_delay  <= pwdata[15:0];
        awg_pkg::PULSE_WIDTH_OFS: pulse_width <= pwdata[15:0];
        awg_pkg::MEM_DEPTH_OFS:   depth       <= pwdata;
        awg_pkg::CLK_DIV_OFS:     clk_div     <= pwdata;
        awg_pkg::SYNC_DIV_OFS:    sync_div    <= pwdata[12:0];
        awg_pkg::SLOW_DIV_OFS:    slow_div    <= pwdata[18:0];
        default:                  ctrl        <= ctrl;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0;
    end
    else if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        awg_pkg::CTRL_OFS:        prdata <= 32'(ctrl);
        awg_pkg::TRIG_DELAY_OFS:  prdata <= 32'(trig_delay);
        awg_pkg::PULSE_WIDTH_OFS: prdata <= 32'(pulse_width);
        awg_pkg::MEM_DEPTH_OFS:   prdata <= depth;
        awg_pkg::CLK_DIV_OFS:     prdata <= clk_div;
        awg_pkg::SYNC_DIV_OFS:    prdata <= 32'(sync_div);
        awg_pkg::SLOW_DIV_OFS:    prdata <= 32'(slow_div);
        awg_pkg::STATUS_OFS:      prdata <= {idx[27:0], 1'b0, state};
        default:                  prdata <= 32'h0;
      endcase
    end
  end

  // ==========================================
  // Pin synchronisers and edges
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
      pin_d    <= 3'h0;
    end
    else
    begin
      pin_meta <= {sync_clk_in, ext_clk_in, trig_in};
      pin_sync <= pin_meta;
      pin_d    <= pin_sync;
    end
  end
  assign trig_s = pin_sync[0];
  // Rising edge of the external clock only
  assign ext_rise = pin_sync[1] && !pin_d[1];
  assign syn_rise = pin_sync[2] && !pin_d[2];
  always_comb
  begin
    unique case (edge_sel)
      awg_pkg::E_RISE: trig_hit = trig_s && !pin_d[0];
      awg_pkg::E_FALL: trig_hit = !trig_s && pin_d[0];
      default:         trig_hit = trig_s != pin_d[0];
    endcase
  end

  // ==========================================
  // Sample tick
  // Source mux in front of the divider
  always_comb
  begin
    unique case (src)
      awg_pkg::C_EXT, awg_pkg::C_EXT_DIV: base_ev = ext_rise;
      awg_pkg::C_SYNC:                    base_ev = syn_rise;
      default:                            base_ev = 1'b1;
    endcase
  end
  assign div_active = (src == awg_pkg::C_PLL) || (src == awg_pkg::C_EXT_DIV)
                   || (src == awg_pkg::C_EXT_REF);
  assign smp_tick   = base_ev && (!div_active || (div_cnt >= clk_div - 32'h1));
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt <= 32'h0;
    end
    else if (smp_tick)
    begin
      div_cnt <= 32'h0;
    end
    else if (base_ev)
    begin
      div_cnt <= div_cnt + 32'h1;
    end
  end

  // ==========================================
  // Trigger and replay sequencer
  assign step = smp_tick && buf_ready;
  // One channel stops only after an odd index
  assign last = (idx == depth - 32'h1) || (closing
             && ((ctrl[awg_pkg::CTRL_CHAN_LSB +: 2] != 2'b00) || idx[0]));

  always_comb
  begin
    next_state = state;
    unique case (state)
      awg_pkg::S_IDLE:    next_state = awg_pkg::S_ARMED;
      // Only the armed state listens to edges
      awg_pkg::S_ARMED:   if (trig_hit) next_state = awg_pkg::S_QUALIFY;
      // Level must stay for the programmed width
      awg_pkg::S_QUALIFY:
        if (trig_s != trig_lvl) next_state = awg_pkg::S_ARMED;
        else if (tcnt >= pulse_width) next_state = awg_pkg::S_DELAY;
      awg_pkg::S_DELAY:   if (tcnt >= trig_delay) next_state = awg_pkg::S_RUN;
      // Mode decides what follows the last sample
      awg_pkg::S_RUN:
        if (step && last)
        begin
          if (closing || mode == awg_pkg::M_RESTART) next_state = awg_pkg::S_ARMED;
          else if (mode == awg_pkg::M_SINGLE) next_state = awg_pkg::S_DONE;
        end
      default:            next_state = state;
    endcase
    if (!ctrl[awg_pkg::CTRL_EN_BIT])
    begin
      next_state = awg_pkg::S_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= awg_pkg::S_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tcnt     <= '0;
      trig_lvl <= 1'b0;
    end
    else if (state != next_state)
    begin
      tcnt <= '0;
      if (next_state == awg_pkg::S_QUALIFY)
      begin
        trig_lvl <= trig_s;
      end
    end
    else if (smp_tick && tcnt != '1)
    begin
      tcnt <= tcnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      idx     <= 32'h0;
      closing <= 1'b0;
    end
    else if (state != awg_pkg::S_RUN)
    begin
      idx     <= 32'h0;
      closing <= 1'b0;
    end
    else
    begin
      // Gate closes when the qualified level goes away
      if (ctrl[awg_pkg::CTRL_GATE_BIT] && trig_s != trig_lvl)
      begin
        closing <= 1'b1;
      end
      if (step)
      begin
        idx <= last ? 32'h0 : idx + 32'h1;
      end
    end
  end

  // High from trigger acceptance to end of replay
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trig_out <= 1'b0;
    end
    else
    begin
      trig_out <= (state == awg_pkg::S_DELAY) || (state == awg_pkg::S_RUN);
    end
  end

  // ==========================================
  // Sync and slow clock dividers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_cnt     <= 12'h0;
      sync_clk_out <= 1'b0;
      slow_cnt     <= 19'h0;
      slow_tick    <= 1'b0;
    end
    else
    begin
      slow_tick <= 1'b0;
      if (smp_tick)
      begin
        if (sync_cnt >= sync_div[12:1] - 12'h1)
        begin
          sync_cnt     <= 12'h0;
          sync_clk_out <= ~sync_clk_out;
        end
        else
        begin
          sync_cnt <= sync_cnt + 12'h1;
        end
        if (slow_cnt >= slow_div - 19'h1)
        begin
          slow_cnt  <= 19'h0;
          slow_tick <= ctrl[awg_pkg::CTRL_SLOW_BIT];
        end
        else
        begin
          slow_cnt <= slow_cnt + 19'h1;
        end
      end
    end
  end

  // ==========================================
  // Output buffer; a stall holds the index, no word dropped
  two_entry_buffer #(.WIDTH(32)) out_buf (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (state == awg_pkg::S_RUN && smp_tick),
    .in_ready  (buf_ready),
    .in_data   (idx),
    .out_valid (smp_valid),
    .out_ready (smp_ready),
    .out_data  (smp_index)
  );

  // ==========================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_armed_hit;
    state == awg_pkg::S_ARMED && trig_hit && ctrl[awg_pkg::CTRL_EN_BIT];
  endsequence
  sequence s_qualify_entered;
    state == awg_pkg::S_QUALIFY && trig_lvl == $past(trig_s);
  endsequence

  a_edge_arms_qual: assert property (s_armed_hit |=> s_qualify_entered)
    else $error("armed trigger edge not taken");
  a_busy_ignores_edge: assert property ($rose(state == awg_pkg::S_QUALIFY)
    |-> $past(state) == awg_pkg::S_ARMED)
    else $error("trigger taken while not armed");
  a_qual_level_lost: assert property (state == awg_pkg::S_QUALIFY && trig_s != trig_lvl
    && ctrl[awg_pkg::CTRL_EN_BIT] |=> state == awg_pkg::S_ARMED)
    else $error("short pulse not rejected");
  a_trig_out_edge: assert property ($rose(trig_out) |-> $past(state) == awg_pkg::S_DELAY
    && $past(state, 2) == awg_pkg::S_QUALIFY)
    else $error("trigger out rose without trigger event");
  a_depth_legal: assert property (depth >= awg_pkg::DEPTH_MIN && depth[1:0] == 2'b00
    && (state != awg_pkg::S_RUN || idx < depth))
    else $error("depth out of range");
  a_gate_end_align: assert property (state == awg_pkg::S_RUN && closing && step && last
    && ctrl[awg_pkg::CTRL_CHAN_LSB +: 2] == 2'b00 && idx != depth - 32'h1
    |-> idx[0])
    else $error("gate end misaligned");
  a_ext_rise_only: assert property (smp_tick && src == awg_pkg::C_EXT
    |-> pin_sync[1] && !pin_d[1])
    else $error("tick without external rising edge");
  a_sync_div_even: assert property (!sync_div[0] && sync_div >= awg_pkg::SYNC_DIV_MIN
    && sync_div <= awg_pkg::SYNC_DIV_MAX)
    else $error("sync divider illegal");
  a_slow_div_step: assert property (slow_div[2:0] == 3'b000
    && slow_div >= awg_pkg::SLOW_DIV_MIN)
    else $error("slow divider illegal");
  a_mode_code_valid: assert property (ctrl[awg_pkg::CTRL_MODE_LSB +: 3] <= 3'b100
    && ctrl[awg_pkg::CTRL_SRC_LSB +: 3] <= 3'b101)
    else $error("mode or source code illegal");
  a_clk_div_bound: assert property (clk_div != 32'h0
    && clk_div <= awg_pkg::CLK_DIV_MAX_INT)
    else $error("clock divider beyond least rate");
endmodule : awg_trig_clk

// >>> dv/awg_src_model.sv
// Far-side model: trigger source and external clock source.
// Assumes pclk from the bench; drives pins low at time 0, then only after rising edges.
module awg_src_model (
  input  wire logic pclk,
  output logic      trig_in,
  output logic      ext_clk_in,
  output logic      sync_clk_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Pins
  // Clocks stand still low between bursts
  initial
  begin
    trig_in = 1'b0;
    ext_clk_in = 1'b0;
    sync_clk_in = 1'b0;
  end
  // level held for whole pclk cycles
  task automatic set_trig(input logic v, input int hold);
    @(posedge pclk);
    trig_in <= v;
    repeat (hold) @(posedge pclk);
  endtask : set_trig
  // Slow edges so the 2-flop sync sees each one; s picks the sync pin
  task automatic ext_edges(input logic s, input int n);
    repeat (n)
    begin
      repeat (3) @(posedge pclk);
      {sync_clk_in, ext_clk_in} <= {s, !s};
      repeat (3) @(posedge pclk);
      {sync_clk_in, ext_clk_in} <= 2'b00;
    end
  endtask : ext_edges
endmodule : awg_src_model

// >>> dv/testbench.sv
// Self-checking bench for the trigger and clock control.
// Assumes APB master here and the source model on the pins.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] a; logic [31:0] d; logic e; logic [31:0] r;} row_t;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        smp_ready = 0, prev_t = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, smp_index, rd;
  logic        pready, pslverr, er, trig_in, ext_clk_in, sync_clk_in;
  logic        trig_out, sync_clk_out, slow_tick, smp_valid;
  logic [31:0] got[$];
  int          err_count = 0, samples_checked = 0, rises = 0, n, m;
  row_t        rows[14];
  int          et[5] = '{0, 1, 2, 0, 1};
  logic        pre[5] = '{0, 1, 1, 1, 0};
  int          ex[5] = '{1, 1, 1, 0, 0};
  logic [7:0]  ra[5] = '{8'h00, 8'h0c, 8'h10, 8'h14, 8'h18};
  logic [31:0] rv[5] = '{awg_pkg::CTRL_RST, awg_pkg::DEPTH_RST, awg_pkg::CLK_DIV_RST,
                         awg_pkg::SYNC_DIV_RST, awg_pkg::SLOW_DIV_RST};
  always #12.5 pclk = ~pclk;
  awg_trig_clk awg_trig_clk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trig_in(trig_in), .ext_clk_in(ext_clk_in),
    .sync_clk_in(sync_clk_in), .trig_out(trig_out), .sync_clk_out(sync_clk_out),
    .slow_tick(slow_tick), .smp_valid(smp_valid), .smp_ready(smp_ready),
    .smp_index(smp_index));
  awg_src_model awg_src_model_inst (.pclk(pclk), .trig_in(trig_in),
    .ext_clk_in(ext_clk_in), .sync_clk_in(sync_clk_in));
  // ==========================================
  // Monitors, on the falling edge to avoid races
  always @(negedge pclk)
  begin
    if (smp_valid === 1'b1 && smp_ready === 1'b1) got.push_back(smp_index);
    if (trig_out === 1'b1 && prev_t !== 1'b1) rises++;
    prev_t = trig_out;
  end
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic gap(input logic s, input int x);
    logic v, p;
    int first, res;
    first = -1;
    res = 0;
    p = 1'b1;
    for (int k = 0; k < 60; k++)
    begin
      @(negedge pclk);
      v = s ? slow_tick : sync_clk_out;
      if (v === 1'b1 && p === 1'b0 && first >= 0 && res == 0) res = k - first;
      if (v === 1'b1 && p === 1'b0 && first < 0) first = k;
      p = v;
    end
    chk("tick gap", 32'(x), 32'(res));
  endtask : gap
  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  initial
  begin
    repeat (20000) @(posedge pclk);
    err_count++;
    give_verdict();
  end
  initial
  begin
    rows = '{'{8'h0c, 32'h6, 1, 32'h8}, '{8'h0c, 32'ha, 1, 32'h8}, '{8'h0c, 32'hc, 0, 32'hc},
      '{8'h14, 32'h7, 1, 32'h2}, '{8'h14, 32'h1ffe, 0, 32'h1ffe},
      '{8'h14, 32'h2000, 1, 32'h1ffe}, '{8'h18, 32'h7fff8, 0, 32'h7fff8},
      '{8'h18, 32'hc, 1, 32'h7fff8}, '{8'h18, 32'h80000, 1, 32'h7fff8},
      '{8'h04, 32'hffff, 0, 32'hffff}, '{8'h08, 32'h0, 0, 32'h0},
      '{8'h10, 32'h0, 1, 32'h1}, '{8'h10, 32'h9c40, 0, 32'h9c40},
      '{8'h10, 32'h9c41, 1, 32'h9c40}};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ra[i])
    begin
      apb(0, ra[i], 0);
      chk("reset value", rv[i], rd);
    end
    foreach (rows[i])
    begin
      apb(1, rows[i].a, rows[i].d);
      chk("write error", 32'(rows[i].e), 32'(er));
      apb(0, rows[i].a, 0);
      chk("read back", rows[i].r, rd);
    end
    // ==========================================
    // Hand cases: refusals, modes, sources
    apb(1, 8'h20, 1);
    chk("unmapped", 1, 32'(er));
    apb(1, awg_pkg::STATUS_OFS, 0);
    chk("status write", 1, 32'(er));
    for (int m = 0; m < 5; m++)
      for (int s = 0; s < 6; s++)
      begin
        apb(1, 8'h00, 32'((s << 6) | m));
        apb(0, 8'h00, 0);
        chk("ctrl", 32'((s << 6) | m), rd);
      end
    apb(1, 8'h00, 32'h100);
    apb(1, 8'h10, 32'd801);
    chk("ref div", 1, 32'(er));
    apb(1, 8'h10, 32'd800);
    chk("ref div", 0, 32'(er));
    // Zero delay, else the row value stalls every run for 64k ticks
    apb(1, 8'h04, 32'h0);
    apb(1, 8'h0c, 32'h8);
    apb(1, 8'h14, 32'h4);
    apb(1, 8'h18, 32'h8);
    apb(1, 8'h00, 32'h1060);
    gap(0, 4);
    gap(1, 8);
    // Stall the sink so the buffer must hold
    awg_src_model_inst.set_trig(1, 30);
    chk("stalled", 0, 32'(got.size()));
    smp_ready <= 1'b1;
    repeat (20) @(posedge pclk);
    chk("count", 8, 32'(got.size()));
    foreach (got[i]) chk("index", 32'(i), got[i]);
    chk("rises", 1, 32'(rises));
    apb(0, awg_pkg::STATUS_OFS, 0);
    chk("state", 5, 32'(rd[2:0]));
    awg_src_model_inst.set_trig(0, 10);
    awg_src_model_inst.set_trig(1, 30);
    chk("rearm", 1, 32'(rises));
    chk("count", 8, 32'(got.size()));
    for (int i = 0; i < 5; i++)
    begin
      awg_src_model_inst.set_trig(pre[i], 6);
      apb(1, 8'h00, 32'h43 | 32'(et[i] << 3));
      n = rises;
      apb(1, 8'h00, 32'h63 | 32'(et[i] << 3));
      repeat (6) @(posedge pclk);
      awg_src_model_inst.set_trig(~pre[i], 40);
      chk("edge", 32'(ex[i]), 32'(rises - n));
    end
    // External clock: no edges, no samples
    apb(1, 8'h00, 32'h80);
    awg_src_model_inst.set_trig(0, 6);
    n = got.size();
    apb(1, 8'h00, 32'ha0);
    repeat (6) @(posedge pclk);
    awg_src_model_inst.set_trig(1, 30);
    chk("no clock", 32'(n), 32'(got.size()));
    awg_src_model_inst.ext_edges(0, 4);
    repeat (12) @(posedge pclk);
    chk("ext ticks", 32'(n + 4), 32'(got.size()));
    // Source switched mid-run; sync pin edges now pace samples
    apb(1, 8'h00, 32'h160);
    awg_src_model_inst.ext_edges(1, 3);
    repeat (12) @(posedge pclk);
    chk("sync ticks", 32'(n + 7), 32'(got.size()));
    // Gated restart: width 10, delay 5, depth large enough not to wrap
    apb(1, 8'h00, 32'h43);
    apb(1, 8'h08, 32'h0a);
    apb(1, 8'h04, 32'h5);
    apb(1, 8'h0c, 32'h40);
    awg_src_model_inst.set_trig(0, 6);
    apb(1, 8'h00, 32'h863);
    n = rises;
    awg_src_model_inst.set_trig(1, 4);
    awg_src_model_inst.set_trig(0, 10);
    chk("short pulse", 32'(n), 32'(rises));
    m = got.size();
    awg_src_model_inst.set_trig(1, 24);
    awg_src_model_inst.set_trig(0, 30);
    chk("gate rises", 32'(n + 1), 32'(rises));
    chk("gate even", 0, 32'((got.size() - m) % 2));
    give_verdict();
  end
endmodule : testbench
